// ==== hw/duart_regs_pkg.sv ====
package duart_regs_pkg;

  // register map, 4-bit byte address on the plain register port
  localparam logic [3:0] ADDR_CHA_MODE     = 4'h0; // channel A mode: rx irq select, error mode
  localparam logic [3:0] ADDR_CHA_STAT_CMD = 4'h1; // read: channel_a_line_status, write: command
  localparam logic [3:0] ADDR_CHB_MODE     = 4'h2;
  localparam logic [3:0] ADDR_CHB_STAT_CMD = 4'h3;
  localparam logic [3:0] ADDR_OUT_ROUTE    = 4'h4; // output_pin_route_config, write only
  localparam logic [3:0] ADDR_OUT_VALUES   = 4'h5; // output_pin_values, write only
  localparam logic [3:0] ADDR_AUX_INCHG    = 4'h6; // write: auxiliary_control, read: input_change_state
  localparam logic [3:0] ADDR_IRQ          = 4'h7; // write: interrupt_mask, read: interrupt_status
  localparam logic [3:0] ADDR_CNT_UPPER    = 4'h8; // counter_upper_byte, write only
  localparam logic [3:0] ADDR_CNT_LOWER    = 4'h9; // counter_lower_byte, write only

  // values after reset
  localparam logic [7:0] REG_RESET_VALUE   = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE   = 8'h00;
  localparam logic [7:0] PIN_RESET_VALUE   = 8'hff; // every pin high, as for all values 0

  // channel mode fields
  localparam int MODE_RXIRQ_SEL_BIT = 6; // 1: fifo_full, 0: receiver_ready
  localparam int MODE_ERR_BLOCK_BIT = 5; // 1: accumulated error mode

  // command field and codes
  localparam int         CMD_FIELD_HI   = 6;
  localparam int         CMD_FIELD_LO   = 4;
  localparam logic [2:0] CMD_RESET_RX   = 3'h2;
  localparam logic [2:0] CMD_RESET_ERR  = 3'h4;
  localparam logic [2:0] CMD_RESET_BRK  = 3'h5;

  // auxiliary control fields
  localparam int AUX_RATE_SET_BIT = 7;
  localparam int AUX_CT_MODE_HI   = 6;
  localparam int AUX_CT_MODE_LO   = 4;

  // output route selections for pins 3 and 2
  localparam logic [1:0] ROUTE_VALUE = 2'h0;
  localparam logic [1:0] ROUTE_SEL1  = 2'h1;
  localparam logic [1:0] ROUTE_SEL2  = 2'h2;

  // receive flag fifo geometry
  localparam int         RX_FIFO_DEPTH = 4;
  localparam int         RX_PTR_W      = 2;
  localparam logic [2:0] RX_FIFO_FULL  = 3'h4;

  // input pin filter: stages filled before first level is trusted
  localparam logic [1:0] SYNC_FILL_DONE = 2'h3;

endpackage : duart_regs_pkg

// ==== hw/duart_status_output_irq_regs.sv ====
`timescale 1ns/1ps
// Function
// - break, framing and parity flags are stored beside each received character.
// - status read gives head character flags in 7:5 and live status in 4:0.
// - reset-error command clears the character-attached flags of that channel.
// - in character mode a flag leaves with its character on readout.
// - in block mode flags accumulate until error reset or receiver reset.
// - status bits: break, framing, parity, overrun, tx empty, tx ready, full, ready.
// - route bits 7 and 6 select tx ready of B and A onto pins 7, 6.
// - route bits 5 and 4 select rx ready/full of B and A onto pins 5, 4.
// - route field 3:2 drives pin 3: value, counter, B 1x tx, B 1x rx clock.
// - route field 1:0 drives pin 2: value, A 16x tx, A 1x tx, A 1x rx.
// - each output pin shows the inverse of its selected bit.
// - auxiliary bit 7 selects which baud rate set is offered.
// - auxiliary bits 3:0 enable change interrupts from input pins 3:0.
// - input change register: deltas in 7:4, present levels in 3:0.
// - interrupt status bit order from input change down to A tx ready.
// - interrupt mask holds one enable per status bit, same positions.
// - counter upper byte holds bits 15:8, lower byte bits 7:0.
// - per-channel mode bit picks ready or full for irq and pin route.
module duart_status_output_irq_regs
  import duart_regs_pkg::*;
(
  input  wire logic        CLK_I,          // 100 MHz clock
  input  wire logic        SRST_I,         // synchronous reset, active high
  input  wire logic [3:0]  ADDR_I,         // register address
  input  wire logic [7:0]  WDATA_I,        // write data
  input  wire logic        WR_I,           // write strobe
  input  wire logic        RD_I,           // read strobe
  output logic      [7:0]  RDATA_O,        // read data, cycle after strobe
  input  wire logic [1:0]  RX_PUSH_I,      // char enters receive fifo, per channel
  input  wire logic [1:0]  RX_POP_I,       // char leaves receive fifo, per channel
  input  wire logic [1:0]  RX_BREAK_I,     // received break with pushed char
  input  wire logic [1:0]  RX_FRAME_I,     // framing error with pushed char
  input  wire logic [1:0]  RX_PARITY_I,    // parity error with pushed char
  input  wire logic [1:0]  TX_EMPTY_I,     // transmitter_empty per channel
  input  wire logic [1:0]  TX_READY_I,     // transmitter_ready per channel
  input  wire logic [1:0]  BREAK_CHANGE_I, // break change event pulse
  input  wire logic        CT_READY_I,     // counter ready level
  input  wire logic        CT_OUT_I,       // counter/timer output
  input  wire logic        TX_CLK16_A_I,   // chan_a_transmit_clock 16x
  input  wire logic        TX_CLK1_A_I,    // chan_a_transmit_clock 1x
  input  wire logic        RX_CLK1_A_I,    // chan_a_receive_clock 1x
  input  wire logic        TX_CLK1_B_I,    // chan_b_transmit_clock 1x
  input  wire logic        RX_CLK1_B_I,    // chan_b_receive_clock 1x
  input  wire logic [3:0]  IN_PIN_I,       // general_input_pin 3:0, asynchronous
  output logic      [7:0]  OUT_PIN_O,      // general_output_pin 7:0
  output logic             IRQ_O,          // interrupt, active high
  output logic             RATE_SET_O,     // baud_rate_generator set select
  output logic      [2:0]  CT_MODE_O,      // counter/timer mode field
  output logic      [15:0] CT_PRESET_O,    // counter/timer preset value
  output logic      [1:0]  RX_RESET_O      // receiver reset pulse per channel
);

  // software-written registers
  logic [7:0]  route_reg;
  logic [7:0]  values_reg;
  logic [7:0]  aux_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  cnt_upper_reg;
  logic [7:0]  cnt_lower_reg;
  logic [7:0]  mode_reg      [0:1];

  // per-channel receive flag fifo and status
  logic [2:0]          flag_mem      [0:1][0:RX_FIFO_DEPTH-1];
  logic [RX_PTR_W-1:0] wr_ptr_reg    [0:1];
  logic [RX_PTR_W-1:0] rd_ptr_reg    [0:1];
  logic [2:0]          count_reg     [0:1];
  logic [2:0]          acc_reg       [0:1];
  logic                overrun_reg   [0:1];
  logic                brk_chg_reg   [0:1];
  logic [7:0]          line_status   [0:1];
  logic [1:0]          rx_sel;
  logic [1:0]          rx_rst;

  // input pin filter and change state
  logic [3:0]  pin_s1_reg;
  logic [3:0]  pin_s2_reg;
  logic [3:0]  pin_s3_reg;
  logic [1:0]  fill_reg;
  logic [3:0]  level_reg;
  logic [3:0]  delta_reg;

  // output regs
  logic [7:0]  rdata_reg;
  logic [7:0]  out_pin_reg;
  logic        irq_reg;
  logic [1:0]  rx_reset_reg;

  // bus decode
  wire         wr_route    = WR_I && (ADDR_I == ADDR_OUT_ROUTE);
  wire         wr_values   = WR_I && (ADDR_I == ADDR_OUT_VALUES);
  wire         wr_aux      = WR_I && (ADDR_I == ADDR_AUX_INCHG);
  wire         wr_mask     = WR_I && (ADDR_I == ADDR_IRQ);
  wire         wr_upper    = WR_I && (ADDR_I == ADDR_CNT_UPPER);
  wire         wr_lower    = WR_I && (ADDR_I == ADDR_CNT_LOWER);
  wire         rd_inchg    = RD_I && (ADDR_I == ADDR_AUX_INCHG);
  // command code field, shared by both channels' command registers
  wire [2:0]   cmd_code    = WDATA_I[CMD_FIELD_HI:CMD_FIELD_LO];

  // one copy of the flag store and line status per channel
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      localparam logic [3:0] MODE_ADDR = (ch == 0) ? ADDR_CHA_MODE : ADDR_CHB_MODE;
      localparam logic [3:0] STAT_ADDR = (ch == 0) ? ADDR_CHA_STAT_CMD : ADDR_CHB_STAT_CMD;

      // command decode; spacing of commands is the host's duty, so each write acts at once
      wire       wr_mode   = WR_I && (ADDR_I == MODE_ADDR);
      wire       wr_cmd    = WR_I && (ADDR_I == STAT_ADDR);
      wire       cmd_rxrst = wr_cmd && (cmd_code == CMD_RESET_RX);
      wire       cmd_brk   = wr_cmd && (cmd_code == CMD_RESET_BRK);
      wire       err_clr   = wr_cmd && ((cmd_code == CMD_RESET_ERR) || cmd_rxrst);
      wire       block     = mode_reg[ch][MODE_ERR_BLOCK_BIT];

      // fifo occupancy
      wire       not_empty = (count_reg[ch] != 3'h0);
      wire       full      = (count_reg[ch] == RX_FIFO_FULL);
      wire       pop       = RX_POP_I[ch] && not_empty;
      wire       push      = RX_PUSH_I[ch] && (!full || pop) && !cmd_rxrst;
      wire       lost      = RX_PUSH_I[ch] && full && !pop && !cmd_rxrst;
      wire [2:0] new_flags = {RX_BREAK_I[ch], RX_FRAME_I[ch], RX_PARITY_I[ch]};

      // head flags vanish with the character in character mode
      wire [2:0] head_flags = not_empty ? flag_mem[ch][rd_ptr_reg[ch]] : 3'h0;
      wire [2:0] err_view   = block ? (acc_reg[ch] | head_flags) : head_flags;
      wire [2:0] acc_next   = err_clr ? 3'h0 : (block ? (acc_reg[ch] | head_flags) : 3'h0);
      wire [2:0] count_next = cmd_rxrst ? 3'h0 :
                              (count_reg[ch] + {2'h0, push} - {2'h0, pop});

      // live bits below the fifo flags; every bit reads 1 when true
      assign line_status[ch] = {err_view,
                                overrun_reg[ch],
                                TX_EMPTY_I[ch],
                                TX_READY_I[ch],
                                full,
                                not_empty};

      // ready or full, chosen per channel, for irq and pin route
      assign rx_sel[ch] = mode_reg[ch][MODE_RXIRQ_SEL_BIT] ? full : not_empty;
      assign rx_rst[ch] = cmd_rxrst;

      // flag storage; an error reset wipes stored flags but a char pushed the same cycle keeps its own
      // no reset: flags behind the read pointer are never shown and are overwritten on push
      always_ff @(posedge CLK_I)
      begin
        if (err_clr)
        begin
          for (int i = 0; i < RX_FIFO_DEPTH; i++)
          begin
            flag_mem[ch][i] <= 3'h0;
          end
        end
        if (push)
        begin
          flag_mem[ch][wr_ptr_reg[ch]] <= new_flags;
        end
      end

      // pointers, accumulation and sticky bits
      always_ff @(posedge CLK_I)
      begin
        if (SRST_I)
        begin
          mode_reg[ch]    <= REG_RESET_VALUE;
          wr_ptr_reg[ch]  <= '0;
          rd_ptr_reg[ch]  <= '0;
          count_reg[ch]   <= 3'h0;
          acc_reg[ch]     <= 3'h0;
          overrun_reg[ch] <= 1'b0;
          brk_chg_reg[ch] <= 1'b0;
        end
        else
        begin
          if (wr_mode)
          begin
            mode_reg[ch] <= WDATA_I;
          end
          if (cmd_rxrst)
          begin
            wr_ptr_reg[ch] <= '0;
            rd_ptr_reg[ch] <= '0;
          end
          else
          begin
            if (push)
            begin
              wr_ptr_reg[ch] <= wr_ptr_reg[ch] + 1'b1;
            end
            if (pop)
            begin
              rd_ptr_reg[ch] <= rd_ptr_reg[ch] + 1'b1;
            end
          end
          // push and pop in one cycle leave the occupancy unchanged
          count_reg[ch]   <= count_next;
          acc_reg[ch]     <= acc_next;
          // set wins over clear for both sticky bits
          overrun_reg[ch] <= lost | (overrun_reg[ch] & ~err_clr);
          brk_chg_reg[ch] <= BREAK_CHANGE_I[ch] | (brk_chg_reg[ch] & ~cmd_brk);
        end
      end
    end
  endgenerate

  // plain control registers
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      route_reg     <= REG_RESET_VALUE;
      values_reg    <= REG_RESET_VALUE;
      aux_reg       <= REG_RESET_VALUE;
      mask_reg      <= REG_RESET_VALUE;
      cnt_upper_reg <= REG_RESET_VALUE;
      cnt_lower_reg <= REG_RESET_VALUE;
    end
    else
    begin
      // a write lands at the strobe edge; none of these read back
      if (wr_route)
      begin
        route_reg <= WDATA_I;
      end
      if (wr_values)
      begin
        values_reg <= WDATA_I;
      end
      if (wr_aux)
      begin
        aux_reg <= WDATA_I;
      end
      if (wr_mask)
      begin
        mask_reg <= WDATA_I;
      end
      if (wr_upper)
      begin
        cnt_upper_reg <= WDATA_I;
      end
      if (wr_lower)
      begin
        cnt_lower_reg <= WDATA_I;
      end
    end
  end

  // input pin synchroniser; only stage two and three are compared
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
      fill_reg   <= 2'h0;
    end
    else
    begin
      pin_s1_reg <= IN_PIN_I;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (fill_reg != SYNC_FILL_DONE)
      begin
        fill_reg <= fill_reg + 2'h1;
      end
    end
  end

  // a change counts once two stages agree; a pin high at the first trusted level after reset counts as a change
  wire       primed    = (fill_reg == SYNC_FILL_DONE);
  wire [3:0] stable    = ~(pin_s2_reg ^ pin_s3_reg);
  wire [3:0] level_nxt = primed ? ((stable & pin_s2_reg) | (~stable & level_reg)) : pin_s3_reg;
  wire [3:0] changed   = primed ? (stable & (pin_s2_reg ^ level_reg)) : 4'h0;

  // a read of the change register clears deltas, but a change in that cycle survives
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      level_reg <= 4'h0;
      delta_reg <= 4'h0;
    end
    else
    begin
      level_reg <= level_nxt;
      delta_reg <= changed | (delta_reg & ~{4{rd_inchg}});
    end
  end

  // status bits follow their sources live; only the sticky events hold until cleared
  // interrupt status assembly
  wire       in_change  = |(delta_reg & aux_reg[3:0]);
  wire [7:0] inchg_view = {delta_reg, level_reg};
  wire [7:0] irq_status = {in_change,
                           brk_chg_reg[1],
                           rx_sel[1],
                           TX_READY_I[1],
                           CT_READY_I,
                           brk_chg_reg[0],
                           rx_sel[0],
                           TX_READY_I[0]};
  wire       irq_next   = |(irq_status & mask_reg);

  // clock routes are resampled on CLK_I, so only clocks well below it come out clean
  // output pin selection before inversion
  wire pin3_sel = (route_reg[3:2] == ROUTE_VALUE) ? values_reg[3] :
                  (route_reg[3:2] == ROUTE_SEL1)  ? CT_OUT_I :
                  (route_reg[3:2] == ROUTE_SEL2)  ? TX_CLK1_B_I : RX_CLK1_B_I;
  wire pin2_sel = (route_reg[1:0] == ROUTE_VALUE) ? values_reg[2] :
                  (route_reg[1:0] == ROUTE_SEL1)  ? TX_CLK16_A_I :
                  (route_reg[1:0] == ROUTE_SEL2)  ? TX_CLK1_A_I : RX_CLK1_A_I;
  // a route bit picks the source only; every pin is inverted on the way out
  wire [7:0] pin_sel = {route_reg[7] ? TX_READY_I[1] : values_reg[7],
                        route_reg[6] ? TX_READY_I[0] : values_reg[6],
                        route_reg[5] ? rx_sel[1]     : values_reg[5],
                        route_reg[4] ? rx_sel[0]     : values_reg[4],
                        pin3_sel,
                        pin2_sel,
                        values_reg[1:0]};

  // status is taken at the strobe edge; a push or pop in that cycle shows at the next read
  // read mux; write-only and unmapped addresses read zero
  wire [7:0] rd_mux = (ADDR_I == ADDR_CHA_MODE)     ? mode_reg[0] :
                      (ADDR_I == ADDR_CHA_STAT_CMD) ? line_status[0] :
                      (ADDR_I == ADDR_CHB_MODE)     ? mode_reg[1] :
                      (ADDR_I == ADDR_CHB_STAT_CMD) ? line_status[1] :
                      (ADDR_I == ADDR_AUX_INCHG)    ? inchg_view :
                      (ADDR_I == ADDR_IRQ)          ? irq_status : READ_IDLE_VALUE;

  // read data and receiver reset pulse; both stand for one cycle only
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      rdata_reg    <= READ_IDLE_VALUE;
      rx_reset_reg <= 2'h0;
    end
    else
    begin
      rdata_reg    <= RD_I ? rd_mux : READ_IDLE_VALUE;
      rx_reset_reg <= rx_rst;
    end
  end

  // registered pins and irq; pins are registered so clock routes gain one cycle of delay
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      out_pin_reg  <= PIN_RESET_VALUE;
      irq_reg      <= 1'b0;
    end
    else
    begin
      out_pin_reg  <= ~pin_sel;
      irq_reg      <= irq_next;
    end
  end

  assign RDATA_O     = rdata_reg;
  assign OUT_PIN_O   = out_pin_reg;
  assign IRQ_O       = irq_reg;
  assign RATE_SET_O  = aux_reg[AUX_RATE_SET_BIT];
  assign CT_MODE_O   = aux_reg[AUX_CT_MODE_HI:AUX_CT_MODE_LO];
  assign CT_PRESET_O = {cnt_upper_reg, cnt_lower_reg};
  assign RX_RESET_O  = rx_reset_reg;

endmodule : duart_status_output_irq_regs

// ==== sim/duart_regs_monitor.sv ====
`timescale 1ns/1ps
// port-level checks for the register bank
module duart_regs_monitor
  import duart_regs_pkg::*;
(
  input wire logic        CLK_I,       // clock
  input wire logic        SRST_I,      // reset
  input wire logic [3:0]  ADDR_I,      // address
  input wire logic [7:0]  WDATA_I,     // write data
  input wire logic        WR_I,        // write strobe
  input wire logic        RD_I,        // read strobe
  input wire logic [7:0]  RDATA_O,     // read data
  input wire logic [1:0]  TX_READY_I,  // tx ready
  input wire logic        CT_READY_I,  // counter ready
  input wire logic [3:0]  IN_PIN_I,    // input pins
  input wire logic [7:0]  OUT_PIN_O,   // output pins
  input wire logic        IRQ_O,       // interrupt
  input wire logic        RATE_SET_O,  // rate set
  input wire logic [15:0] CT_PRESET_O  // preset
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic [7:0] route_q, val_q, mask_q;
  logic [1:0] sel_hi;
  // shadows of write-only registers: pins and irq cannot be judged without them
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      {route_q, val_q, mask_q} <= 24'h000000;
    else if (WR_I && ADDR_I == ADDR_OUT_ROUTE)
      route_q <= WDATA_I;
    else if (WR_I && ADDR_I == ADDR_OUT_VALUES)
      val_q <= WDATA_I;
    else if (WR_I && ADDR_I == ADDR_IRQ)
      mask_q <= WDATA_I;
  end
  // source picked for the two top pins
  assign sel_hi = {route_q[7] ? TX_READY_I[1] : val_q[7], route_q[6] ? TX_READY_I[0] : val_q[6]};

  ct_upper_a: assert property (WR_I && ADDR_I == ADDR_CNT_UPPER |=> CT_PRESET_O[15:8] == $past(WDATA_I))
    else $error("counter upper byte wrong");
  ct_lower_a: assert property (WR_I && ADDR_I == ADDR_CNT_LOWER |=> CT_PRESET_O[7:0] == $past(WDATA_I))
    else $error("counter lower byte wrong");
  rate_set_a: assert property (WR_I && ADDR_I == ADDR_AUX_INCHG |=> RATE_SET_O == $past(WDATA_I[7]))
    else $error("rate set select wrong");
  stat_live_a: assert property (RD_I && ADDR_I == ADDR_CHA_STAT_CMD |=> RDATA_O[2] == $past(TX_READY_I[0]))
    else $error("status tx ready wrong");
  isr_live_a: assert property (RD_I && ADDR_I == ADDR_IRQ
    |=> RDATA_O[4] == $past(TX_READY_I[1]) && RDATA_O[3] == $past(CT_READY_I))
    else $error("interrupt status bits wrong");
  in_level_a: assert property ($stable(IN_PIN_I)[*6] ##0 (RD_I && ADDR_I == ADDR_AUX_INCHG)
    |=> RDATA_O[3:0] == $past(IN_PIN_I))
    else $error("input level wrong");
  pins_high_a: assert property (1'b1 |=> OUT_PIN_O[7:6] == ~$past(sel_hi))
    else $error("routed top pins wrong");
  pins_value_a: assert property (1'b1 |=> OUT_PIN_O[1:0] == ~$past(val_q[1:0]))
    else $error("low pins not inverted values");
  mask_off_a: assert property (mask_q == 8'h00 |=> !IRQ_O)
    else $error("irq with all masked");
  irq_ct_a: assert property (mask_q[3] && CT_READY_I |=> IRQ_O)
    else $error("irq missing for counter ready");
endmodule : duart_regs_monitor

bind duart_status_output_irq_regs duart_regs_monitor monitor (.CLK_I, .SRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
  .RDATA_O, .TX_READY_I, .CT_READY_I, .IN_PIN_I, .OUT_PIN_O, .IRQ_O, .RATE_SET_O, .CT_PRESET_O);

// ==== sim/host_bus_model.sv ====
`timescale 1ns/1ps
// host processor on the register port
module host_bus_model
  import duart_regs_pkg::*;
(
  input  wire logic       clk_i,   // bench clock
  output logic      [3:0] addr_o,  // address
  output logic      [7:0] wdata_o, // write data
  output logic            wr_o,    // write strobe
  output logic            rd_o     // read strobe
);
  // idle bus at time zero
  initial
  begin
    addr_o = 4'hf;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write; lines scrambled afterwards so stale values are not trusted
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : write_reg
  // one-cycle read; data is collected by the bench watcher
  task automatic read_reg(input logic [3:0] a);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask : read_reg
  // channel command, then the spacing the device needs
  task automatic command(input logic [3:0] a, input logic [2:0] code);
    write_reg(a, {1'b0, code, 4'h0});
    repeat (3) @(posedge clk_i);
  endtask : command
endmodule : host_bus_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
// bench for the status, output-port and interrupt registers
module tb
  import duart_regs_pkg::*;
();
  logic        clk, srst, wr, rd, irq, rate_set;
  logic        rd_prev = 1'b0;
  logic [2:0]  ct_mode;
  logic        ct_ready, ct_out, txc16a, txc1a, rxc1a, txc1b, rxc1b;
  logic [3:0]  addr, in_pin;
  logic [7:0]  wdata, rdata, out_pin;
  logic [1:0]  push, pop, brk, frm, par, tx_empty, tx_ready, brk_chg, rx_reset;
  logic [15:0] ct_preset;
  logic [31:0] r;
  logic [7:0]  exp_q[$];
  int          mismatches, comparisons, cycles;
  integer      seed = 32'hf8bc0b00;

  duart_status_output_irq_regs dut (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .RX_PUSH_I(push), .RX_POP_I(pop), .RX_BREAK_I(brk), .RX_FRAME_I(frm),
    .RX_PARITY_I(par), .TX_EMPTY_I(tx_empty), .TX_READY_I(tx_ready), .BREAK_CHANGE_I(brk_chg),
    .CT_READY_I(ct_ready), .CT_OUT_I(ct_out), .TX_CLK16_A_I(txc16a), .TX_CLK1_A_I(txc1a), .RX_CLK1_A_I(rxc1a),
    .TX_CLK1_B_I(txc1b), .RX_CLK1_B_I(rxc1b), .IN_PIN_I(in_pin), .OUT_PIN_O(out_pin), .IRQ_O(irq),
    .RATE_SET_O(rate_set), .CT_MODE_O(ct_mode), .CT_PRESET_O(ct_preset), .RX_RESET_O(rx_reset));
  host_bus_model host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic close_out();
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // note the expected read value, then issue the read
  task automatic expect_rd(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    host.read_reg(a);
  endtask : expect_rd

  // one receive push (with flags) or pop on a channel
  task automatic rx_event(input int ch, input logic pu, input logic [2:0] f);
    @(posedge clk);
    push[ch] <= pu;
    pop[ch] <= !pu;
    {brk, frm, par} <= {{2{f[2]}}, {2{f[1]}}, {2{f[0]}}};
    @(posedge clk);
    {push, pop} <= 4'h0;
  endtask : rx_event

  function automatic logic [7:0] stat(input int ch, input logic [2:0] e, input logic ov, fl, rdy);
    return {e, ov, tx_empty[ch], tx_ready[ch], fl, rdy};
  endfunction : stat

  function automatic logic [7:0] interrupt_status(input logic chg, input logic bka);
    return {chg, 2'b00, tx_ready[1], ct_ready, bka, 1'b0, tx_ready[0]};
  endfunction : interrupt_status

  // read data lands the cycle after the strobe; match it with the oldest note
  always @(posedge clk)
  begin
    if (rd_prev)
      check("read data", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_prev <= rd;
    cycles++;
    if (cycles == 4000)
    begin
      mismatches++;
      close_out();
    end
  end

  initial
  begin : main
    logic [7:0] v;
    logic [3:0] a, m, s3, s2;
    {push, pop, brk, frm, par, brk_chg} = 12'h000;
    {ct_ready, ct_out, txc16a, txc1a, rxc1a, txc1b, rxc1b} = 7'h00;
    in_pin = 4'h0;
    srst = 1'b1;
    r = $random(seed);
    {tx_empty, tx_ready} = r[3:0];
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check("pins after reset", {8'h00, out_pin}, 16'h00ff);
    // counter preset and auxiliary control
    r = $random(seed);
    host.write_reg(ADDR_CNT_UPPER, r[15:8]);
    host.write_reg(ADDR_CNT_LOWER, r[7:0]);
    host.write_reg(ADDR_AUX_INCHG, {r[23:20], 4'h0});
    @(posedge clk);
    check("preset", ct_preset, r[15:0]);
    check("rate set", {15'h0, rate_set}, {15'h0, r[23]});
    check("ct mode", {13'h0, ct_mode}, {13'h0, r[22:20]});
    // input change: masked first, then enabled, then cleared by reading
    ct_ready <= r[24];
    in_pin <= 4'h5;
    repeat (6) @(posedge clk);
    expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0));
    host.write_reg(ADDR_AUX_INCHG, 8'h0f);
    expect_rd(ADDR_IRQ, interrupt_status(1'b1, 1'b0));
    expect_rd(ADDR_AUX_INCHG, 8'h55);
    expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0));
    // break change event on channel A, then its clearing command
    @(posedge clk);
    brk_chg <= 2'b01;
    @(posedge clk);
    brk_chg <= 2'b00;
    expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b1));
    host.command(ADDR_CHA_STAT_CMD, CMD_RESET_BRK);
    expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0));
    // one mask bit at a time against the live status
    ct_ready <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      host.write_reg(ADDR_IRQ, 8'h01 << i);
      repeat (2) @(posedge clk);
      v = interrupt_status(1'b0, 1'b0);
      check("irq", {15'h0, irq}, {15'h0, v[i]});
    end
    host.write_reg(ADDR_IRQ, 8'h00);
    // output pins: plain values, status routes, then every clock route code
    r = $random(seed);
    v = r[7:0];
    host.write_reg(ADDR_OUT_VALUES, v);
    repeat (2) @(posedge clk);
    check("pins", {8'h00, out_pin}, {8'h00, ~v});
    host.write_reg(ADDR_OUT_ROUTE, 8'hf0);
    repeat (2) @(posedge clk);
    check("pins", {8'h00, out_pin}, {8'h00, ~tx_ready[1], ~tx_ready[0], 2'b11, ~v[3:0]});
    for (int c = 0; c < 4; c++)
    begin
      host.write_reg(ADDR_OUT_ROUTE, {4'h0, c[1:0], c[1:0]});
      r = $random(seed);
      {ct_out, txc16a, txc1a, rxc1a, txc1b, rxc1b} <= r[5:0];
      repeat (2) @(posedge clk);
      s3 = {rxc1b, txc1b, ct_out, v[3]};
      s2 = {rxc1a, txc1a, txc16a, v[2]};
      check("pin 3", {15'h0, out_pin[3]}, {15'h0, ~s3[c]});
      check("pin 2", {15'h0, out_pin[2]}, {15'h0, ~s2[c]});
    end
    // receive flags per channel: character mode, block mode, full, overrun, reset
    for (int ch = 0; ch < 2; ch++)
    begin
      a = ch ? ADDR_CHB_STAT_CMD : ADDR_CHA_STAT_CMD;
      m = ch ? ADDR_CHB_MODE : ADDR_CHA_MODE;
      rx_event(ch, 1'b1, 3'b101);
      rx_event(ch, 1'b1, 3'b000);
      expect_rd(a, stat(ch, 3'b101, 1'b0, 1'b0, 1'b1));
      expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0) | (8'h02 << (4 * ch)));
      rx_event(ch, 1'b0, 3'b000);
      expect_rd(a, stat(ch, 3'b000, 1'b0, 1'b0, 1'b1));
      host.write_reg(m, 8'h60);
      host.command(a, CMD_RESET_ERR);
      rx_event(ch, 1'b1, 3'b010);
      rx_event(ch, 1'b0, 3'b000);
      rx_event(ch, 1'b1, 3'b000);
      rx_event(ch, 1'b0, 3'b000);
      expect_rd(a, stat(ch, 3'b010, 1'b0, 1'b0, 1'b1));
      host.command(a, CMD_RESET_ERR);
      expect_rd(a, stat(ch, 3'b000, 1'b0, 1'b0, 1'b1));
      expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0));
      repeat (3) rx_event(ch, 1'b1, 3'b000);
      expect_rd(a, stat(ch, 3'b000, 1'b0, 1'b1, 1'b1));
      expect_rd(ADDR_IRQ, interrupt_status(1'b0, 1'b0) | (8'h02 << (4 * ch)));
      rx_event(ch, 1'b1, 3'b000);
      expect_rd(a, stat(ch, 3'b000, 1'b1, 1'b1, 1'b1));
      host.write_reg(a, {1'b0, CMD_RESET_RX, 4'h0});
      @(posedge clk);
      check("rx reset", {14'h0, rx_reset}, {14'h0, 2'b01 << ch});
      expect_rd(a, stat(ch, 3'b000, 1'b0, 1'b0, 1'b0));
      check("rx reset", {14'h0, rx_reset}, 16'h0000);
    end
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule : tb
